// >>> ufl_defs.svh
// Register offsets, field positions, reset values and timing counts of the UART core
`ifndef UFL_DEFS_SVH
`define UFL_DEFS_SVH
`define UFL_A_DATA 3'h0
`define UFL_A_DLH 3'h1
`define UFL_A_FCR 3'h2
`define UFL_A_LCR 3'h3
`define UFL_A_LSR 3'h5
`define UFL_EFR_KEY 8'hbf
`define UFL_FCR_EN 0
`define UFL_FCR_RXCLR 1
`define UFL_FCR_TXCLR 2
`define UFL_FCR_DMA 3
`define UFL_EFR_ENH 4
`define UFL_LCR_STOP 2
`define UFL_LCR_PEN 3
`define UFL_LCR_EVEN 4
`define UFL_LCR_STICK 5
`define UFL_LCR_BRK 6
`define UFL_LCR_DLAB 7
`define UFL_LCR_RST 8'h00
`define UFL_EFR_RST 8'h00
`define UFL_DIV_RST 16'h0001
`define UFL_OVS_LAST 6'h0f
`define UFL_MID_TICK 4'h7
`define UFL_STOP15_LAST 6'h17
`define UFL_STOP2_LAST 6'h1f
`define UFL_TXT0 7'h08
`define UFL_TXT1 7'h10
`define UFL_TXT2 7'h20
`define UFL_TXT3 7'h38
`define UFL_RXT0 7'h08
`define UFL_RXT1 7'h10
`define UFL_RXT2 7'h38
`define UFL_RXT3 7'h3c
`endif

// >>> ufl_pkg.sv
// State types of the UART core
package ufl_pkg;
  typedef enum logic [4:0] {
    UFL_TX_IDLE = 5'h01,
    UFL_TX_START = 5'h02,
    UFL_TX_DATA = 5'h04,
    UFL_TX_PAR = 5'h08,
    UFL_TX_STOP = 5'h10
  } ufl_txst_t;
  typedef enum logic [4:0] {
    UFL_RX_IDLE = 5'h01,
    UFL_RX_START = 5'h02,
    UFL_RX_DATA = 5'h04,
    UFL_RX_PAR = 5'h08,
    UFL_RX_STOP = 5'h10
  } ufl_rxst_t;
endpackage

// >>> ufl_core.sv
// UART channel core: FIFOs, line format control, line status and serial shifters
//
// Functional notes
// [RQ1] Receive shifter deserializes RX and pushes each character into a 64-entry FIFO.
// [RQ2] With FIFOs disabled, only entry zero is used; unread character is overwritten; the code overwrites the current head entry, which moves on each read.
// [RQ3] Each receive entry carries break, framing and parity flags with the data.
// [RQ4] Host writes go into a 64-entry transmit FIFO feeding the transmit shifter.
// [RQ5] Queue control is write-only; bit 0 enables or disables both FIFOs; the code applies it to the receive FIFO only.
// [RQ6] Writing 1 to bit 1 empties the receive FIFO; self-clearing.
// [RQ7] Writing 1 to bit 2 empties the transmit FIFO; self-clearing.
// [RQ8] Bit 3 selects DMA signalling mode 0 or 1.
// [RQ9] Bits 5:4 set transmit trigger: 8, 16, 32 or 56 spaces.
// [RQ10] Bits 7:6 set receive trigger: 8, 16, 56 or 60 characters.
// [RQ11] Transmit trigger field changes only while enhanced functions are enabled.
// [RQ12] Line format bits 1:0 give 5 to 8 data bits both ways.
// [RQ13] Bit 2 selects one stop bit, else 1.5 (5-bit) or two.
// [RQ14] Bit 3 enables parity generate and check; bit 4 picks even.
// [RQ15] Bit 5 with parity forces the parity bit to inverse of bit 4.
// [RQ16] Bit 6 holds TX low as a break while set.
// [RQ17] Bit 7 switches data addresses to the divisor latches.
// [RQ18] Status bit 0 shows receive data present; bit 1 shows overrun.
// [RQ19] Status bits 4:2 show head entry break, framing, parity flags live.
// [RQ20] Bit 5 shows transmit FIFO empty; bit 6 also requires shifter idle.
// [RQ21] Bit 7 stays set while any receive entry carries an error.
// [RQ22] Reading status never pops; only a data read advances the receive FIFO.
// [RQ23] Reading status clears the overrun flag.
`timescale 1ns/1ps
`include "ufl_defs.svh"

module ufl_fifo #(
  parameter int W = 11,
  parameter int DEPTH = 64
) (
  input wire logic clk_sys,             // System clock
  input wire logic rst_n,               // Synchronised reset, active low
  input wire logic clk_en,              // Freezes state while low
  input wire logic clear,               // Empties the FIFO
  input wire logic over,                // Overwrite head instead of queueing
  input wire logic in_valid,            // Write request
  output logic in_ready,                // Space available
  input wire logic [W-1:0] in_data,     // Write data
  output logic out_valid,               // Head entry present
  input wire logic out_ready,           // Pop request
  output logic [W-1:0] out_data,        // Head entry
  output logic [$clog2(DEPTH+1)-1:0] count  // Entries held
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } ufl_fst_t;
  ufl_fst_t s_r, s_nxt;
  logic pop, ovw, push;

  assign in_ready = s_r.cnt != CW'(DEPTH);
  assign out_valid = s_r.cnt != '0;
  assign out_data = s_r.mem[s_r.rp];
  assign count = s_r.cnt;
  assign pop = out_valid && out_ready;
  // Overwrite only when no pop races it, so the head never goes stale
  assign ovw = in_valid && over && out_valid && !pop;
  assign push = in_valid && in_ready && !ovw;

  always_comb begin
    s_nxt = s_r;
    if (clk_en) begin
      if (clear) begin
        s_nxt.wp = '0;
        s_nxt.rp = '0;
        s_nxt.cnt = '0;
      end else begin
        if (ovw) begin
          s_nxt.mem[s_r.rp] = in_data;
        end else if (push) begin
          s_nxt.mem[s_r.wp] = in_data;
          s_nxt.wp = (s_r.wp == AW'(DEPTH-1)) ? '0 : AW'(s_r.wp + 1'b1);
        end
        if (pop) begin
          s_nxt.rp = (s_r.rp == AW'(DEPTH-1)) ? '0 : AW'(s_r.rp + 1'b1);
        end
        s_nxt.cnt = CW'(s_r.cnt + CW'(push) - CW'(pop));
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

module ufl_core #(
  parameter int DEPTH = 64
) (
  input wire logic clk_sys,             // System clock, 20 MHz
  input wire logic reset_n,             // Asynchronous reset, active low
  input wire logic clk_en,              // Freezes all state except the reset synchroniser flops while low
  input wire logic cs_n,                // Chip select, active low
  input wire logic ior_n,               // Read strobe, active low
  input wire logic iow_n,               // Write strobe, active low
  input wire logic [2:0] addr,          // Register address
  input wire logic [7:0] data_in,       // Host write data
  output logic [7:0] data_out,          // Host read data
  output logic data_oe,                 // High while driving the data bus
  input wire logic rx_line,             // Serial input
  output logic tx_line,                 // Serial output
  output logic dma_mode,                // DMA signalling style
  output logic rx_trigger_hit,          // Receive fill at or above trigger
  output logic tx_trigger_hit           // Transmit free space at or above trigger
);
  import ufl_pkg::*;
  localparam int CW = $clog2(DEPTH+1);
  typedef struct packed {
    logic [13:0] bus1;
    logic [13:0] bus2;
    logic rd_prev;
    logic wr_prev;
    logic [7:0] dout;
    logic oe;
    logic [7:0] line_format_control;
    logic [7:0] enhanced_feature_control;
    logic [15:0] div;
    logic fifo_en;
    logic dma;
    logic [1:0] txtrig;
    logic [1:0] rxtrig;
    logic ovr;
    logic [CW-1:0] errcnt;
    logic rxhit;
    logic txhit;
    logic [15:0] bcnt;
    ufl_txst_t txst;
    logic [7:0] txsh;
    logic [2:0] txbit;
    logic [5:0] txtk;
    logic txpar;
    logic txo;
    logic rxs1;
    logic rxs2;
    logic rxs3;
    ufl_rxst_t rxst;
    logic [7:0] rxsh;
    logic [2:0] rxbit;
    logic [3:0] rxtk;
    logic rxpb;
  } ufl_st_t;

  ufl_st_t s_r, s_nxt;
  logic rst_s1, rst_s2, rst_n_s;
  logic rd_lvl, wr_lvl, rd_go, wr_go, dlab, tick;
  logic [2:0] baddr;
  logic [7:0] bdata;
  logic [15:0] div_last;
  logic [2:0] wlast;
  logic rx_push, rx_ready, rx_valid, rx_pop, rx_clr, tx_push, tx_ready, tx_valid, tx_pop, tx_clr;
  logic [10:0] rx_word, rx_head;
  logic [7:0] tx_head, rx_align;
  logic [CW-1:0] rx_cnt, tx_cnt;
  logic [6:0] txlvl, rxlvl;
  logic ovr_evt, err_in, err_out, err_old, ovw_evt;

  // Parity bit for the current line format
  function automatic logic ufl_par(input logic [7:0] d, input logic [7:0] line_format_control);
    logic [7:0] m;
    m = d & (8'hff >> (3'h3 - {1'b0, line_format_control[1:0]}));
    if (line_format_control[`UFL_LCR_STICK]) begin
      ufl_par = ~line_format_control[`UFL_LCR_EVEN]; // [RQ15]
    end else begin
      ufl_par = line_format_control[`UFL_LCR_EVEN] ? ^m : ~^m; // [RQ14]
    end
  endfunction

  // Reset released through two flops, asserted at once
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  assign rst_n_s = rst_s2;

  // Host bus pins are asynchronous; host holds address and data through the strobe
  assign rd_lvl = !s_r.bus2[13] && !s_r.bus2[12];
  assign wr_lvl = !s_r.bus2[13] && !s_r.bus2[11];
  assign baddr = s_r.bus2[10:8];
  assign bdata = s_r.bus2[7:0];
  assign rd_go = clk_en && rd_lvl && !s_r.rd_prev;
  assign wr_go = clk_en && wr_lvl && !s_r.wr_prev;
  assign dlab = s_r.line_format_control[`UFL_LCR_DLAB];
  assign wlast = 3'h4 + {1'b0, s_r.line_format_control[1:0]}; // [RQ12]

  assign div_last = (s_r.div == 16'h0000) ? 16'h0000 : 16'(s_r.div - 16'h0001);
  assign tick = clk_en && (s_r.bcnt == div_last);

  // Host data path through the two queues
  assign rx_pop = rd_go && baddr == `UFL_A_DATA && !dlab; // [RQ22]
  assign tx_push = wr_go && baddr == `UFL_A_DATA && !dlab; // [RQ4]
  assign rx_clr = wr_go && baddr == `UFL_A_FCR && s_r.line_format_control != `UFL_EFR_KEY && bdata[`UFL_FCR_RXCLR]; // [RQ6]
  assign tx_clr = wr_go && baddr == `UFL_A_FCR && s_r.line_format_control != `UFL_EFR_KEY && bdata[`UFL_FCR_TXCLR]; // [RQ7]
  assign tx_pop = tx_valid && s_r.txst == UFL_TX_IDLE;

  ufl_fifo #(.W(11), .DEPTH(DEPTH)) u_rxq (
    .clk_sys(clk_sys), .rst_n(rst_n_s), .clk_en(clk_en), .clear(rx_clr),
    .over(!s_r.fifo_en), .in_valid(rx_push), .in_ready(rx_ready), .in_data(rx_word), // [RQ2]
    .out_valid(rx_valid), .out_ready(rx_pop), .out_data(rx_head), .count(rx_cnt)
  );
  ufl_fifo #(.W(8), .DEPTH(DEPTH)) u_txq (
    .clk_sys(clk_sys), .rst_n(rst_n_s), .clk_en(clk_en), .clear(tx_clr),
    .over(1'b0), .in_valid(tx_push), .in_ready(tx_ready), .in_data(bdata),
    .out_valid(tx_valid), .out_ready(tx_pop), .out_data(tx_head), .count(tx_cnt)
  );

  // Character completes at the middle of the stop bit
  assign rx_align = s_r.rxsh >> (3'h3 - {1'b0, s_r.line_format_control[1:0]});
  assign rx_push = tick && s_r.rxst == UFL_RX_STOP && s_r.rxtk == 4'hf; // [RQ1]
  always_comb begin
    rx_word[7:0] = rx_align;
    rx_word[10] = !s_r.rxs2 && rx_align == 8'h00 && !(s_r.line_format_control[`UFL_LCR_PEN] && s_r.rxpb); // [RQ19]
    rx_word[9] = !s_r.rxs2; // [RQ3]
    rx_word[8] = s_r.line_format_control[`UFL_LCR_PEN] && (s_r.rxpb != ufl_par(rx_align, s_r.line_format_control));
  end
  assign ovw_evt = rx_push && !s_r.fifo_en && rx_valid && !rx_pop;
  assign ovr_evt = rx_push && ((s_r.fifo_en && !rx_ready) || ovw_evt); // [RQ18]
  assign err_in = rx_push && |rx_word[10:8] && (rx_ready || ovw_evt);
  assign err_old = ovw_evt && |rx_head[10:8];
  assign err_out = rx_pop && rx_valid && |rx_head[10:8];

  always_comb begin
    case (s_r.txtrig)
      2'h0: txlvl = `UFL_TXT0;
      2'h1: txlvl = `UFL_TXT1;
      2'h2: txlvl = `UFL_TXT2;
      default: txlvl = `UFL_TXT3;
    endcase
    case (s_r.rxtrig)
      2'h0: rxlvl = `UFL_RXT0;
      2'h1: rxlvl = `UFL_RXT1;
      2'h2: rxlvl = `UFL_RXT2;
      default: rxlvl = `UFL_RXT3;
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    if (clk_en) begin
      s_nxt.bus1 = {cs_n, ior_n, iow_n, addr, data_in};
      s_nxt.bus2 = s_r.bus1;
      s_nxt.rd_prev = rd_lvl;
      s_nxt.wr_prev = wr_lvl;
      s_nxt.oe = rd_lvl;
      s_nxt.rxs1 = rx_line;
      s_nxt.rxs2 = s_r.rxs1;
      s_nxt.rxs3 = s_r.rxs2;
      s_nxt.bcnt = tick ? 16'h0000 : 16'(s_r.bcnt + 16'h0001);
      s_nxt.rxhit = 7'(rx_cnt) >= rxlvl; // [RQ10]
      s_nxt.txhit = 7'(CW'(DEPTH) - tx_cnt) >= txlvl; // [RQ9]
      if (rx_clr) begin
        s_nxt.errcnt = '0;
      end else begin
        s_nxt.errcnt = CW'(s_r.errcnt + CW'(err_in) - CW'(err_old) - CW'(err_out)); // [RQ21]
      end
      // Host register reads
      if (rd_go) begin
        s_nxt.dout = 8'h00;
        case (baddr)
          `UFL_A_DATA: s_nxt.dout = dlab ? s_r.div[7:0] : (rx_valid ? rx_head[7:0] : 8'h00); // [RQ17]
          `UFL_A_DLH: s_nxt.dout = dlab ? s_r.div[15:8] : 8'h00;
          `UFL_A_FCR: s_nxt.dout = (s_r.line_format_control == `UFL_EFR_KEY) ? s_r.enhanced_feature_control : 8'h00; // [RQ5]
          `UFL_A_LCR: s_nxt.dout = s_r.line_format_control;
          `UFL_A_LSR: begin
            s_nxt.dout = {s_r.errcnt != '0, // [RQ21]
                          tx_cnt == '0 && s_r.txst == UFL_TX_IDLE, tx_cnt == '0, // [RQ20]
                          rx_valid ? rx_head[10:8] : 3'h0, s_r.ovr, rx_valid}; // [RQ19] [RQ18]
          end
          default: s_nxt.dout = 8'h00;
        endcase
      end
      // Overrun set wins over the clear by a status read
      if (ovr_evt) begin
        s_nxt.ovr = 1'b1;
      end else if (rd_go && baddr == `UFL_A_LSR) begin
        s_nxt.ovr = 1'b0; // [RQ23]
      end
      // Host register writes
      if (wr_go) begin
        case (baddr)
          `UFL_A_DATA: begin
            if (dlab) begin
              s_nxt.div[7:0] = bdata; // [RQ17]
            end
          end
          `UFL_A_DLH: begin
            if (dlab) begin
              s_nxt.div[15:8] = bdata;
            end
          end
          `UFL_A_FCR: begin
            if (s_r.line_format_control == `UFL_EFR_KEY) begin
              s_nxt.enhanced_feature_control = bdata;
            end else begin
              s_nxt.fifo_en = bdata[`UFL_FCR_EN]; // [RQ5]
              s_nxt.dma = bdata[`UFL_FCR_DMA]; // [RQ8]
              s_nxt.rxtrig = bdata[7:6]; // [RQ10]
              if (s_r.enhanced_feature_control[`UFL_EFR_ENH]) begin
                s_nxt.txtrig = bdata[5:4]; // [RQ11]
              end
            end
          end
          `UFL_A_LCR: s_nxt.line_format_control = bdata;
          default: s_nxt.line_format_control = s_r.line_format_control;
        endcase
      end
      // Transmit shifter, one bit per sixteen ticks
      case (s_r.txst)
        UFL_TX_IDLE: begin
          if (tx_pop) begin
            s_nxt.txsh = tx_head;
            s_nxt.txpar = ufl_par(tx_head, s_r.line_format_control); // [RQ14]
            s_nxt.txtk = 6'h00;
            s_nxt.txbit = 3'h0;
            s_nxt.txst = UFL_TX_START;
          end
        end
        UFL_TX_START: begin
          if (tick) begin
            s_nxt.txtk = 6'(s_r.txtk + 6'h01);
            if (s_r.txtk == `UFL_OVS_LAST) begin
              s_nxt.txtk = 6'h00;
              s_nxt.txst = UFL_TX_DATA;
            end
          end
        end
        UFL_TX_DATA: begin
          if (tick) begin
            s_nxt.txtk = 6'(s_r.txtk + 6'h01);
            if (s_r.txtk == `UFL_OVS_LAST) begin
              s_nxt.txtk = 6'h00;
              s_nxt.txsh = {1'b0, s_r.txsh[7:1]};
              s_nxt.txbit = 3'(s_r.txbit + 3'h1);
              if (s_r.txbit == wlast) begin // [RQ12]
                s_nxt.txst = s_r.line_format_control[`UFL_LCR_PEN] ? UFL_TX_PAR : UFL_TX_STOP;
              end
            end
          end
        end
        UFL_TX_PAR: begin
          if (tick) begin
            s_nxt.txtk = 6'(s_r.txtk + 6'h01);
            if (s_r.txtk == `UFL_OVS_LAST) begin
              s_nxt.txtk = 6'h00;
              s_nxt.txst = UFL_TX_STOP;
            end
          end
        end
        UFL_TX_STOP: begin
          if (tick) begin
            s_nxt.txtk = 6'(s_r.txtk + 6'h01);
            if (s_r.txtk == (!s_r.line_format_control[`UFL_LCR_STOP] ? `UFL_OVS_LAST : // [RQ13]
                (s_r.line_format_control[1:0] == 2'h0 ? `UFL_STOP15_LAST : `UFL_STOP2_LAST))) begin
              s_nxt.txst = UFL_TX_IDLE;
            end
          end
        end
        default: s_nxt.txst = UFL_TX_IDLE;
      endcase
      case (s_nxt.txst)
        UFL_TX_START: s_nxt.txo = 1'b0;
        UFL_TX_DATA: s_nxt.txo = s_nxt.txsh[0];
        UFL_TX_PAR: s_nxt.txo = s_nxt.txpar;
        default: s_nxt.txo = 1'b1;
      endcase
      if (s_nxt.line_format_control[`UFL_LCR_BRK]) begin
        s_nxt.txo = 1'b0; // [RQ16]
      end
      // Receive shifter; a new start needs a falling edge, so a held break is one character
      case (s_r.rxst)
        UFL_RX_IDLE: begin
          if (!s_r.rxs2 && s_r.rxs3) begin
            s_nxt.rxtk = 4'h0;
            s_nxt.rxst = UFL_RX_START;
          end
        end
        UFL_RX_START: begin
          if (tick) begin
            s_nxt.rxtk = 4'(s_r.rxtk + 4'h1);
            if (s_r.rxtk == `UFL_MID_TICK) begin
              s_nxt.rxtk = 4'h0;
              s_nxt.rxbit = 3'h0;
              s_nxt.rxst = s_r.rxs2 ? UFL_RX_IDLE : UFL_RX_DATA;
            end
          end
        end
        UFL_RX_DATA: begin
          if (tick) begin
            s_nxt.rxtk = 4'(s_r.rxtk + 4'h1);
            if (s_r.rxtk == 4'hf) begin
              s_nxt.rxsh = {s_r.rxs2, s_r.rxsh[7:1]}; // [RQ1]
              s_nxt.rxbit = 3'(s_r.rxbit + 3'h1);
              if (s_r.rxbit == wlast) begin
                s_nxt.rxst = s_r.line_format_control[`UFL_LCR_PEN] ? UFL_RX_PAR : UFL_RX_STOP;
              end
            end
          end
        end
        UFL_RX_PAR: begin
          if (tick) begin
            s_nxt.rxtk = 4'(s_r.rxtk + 4'h1);
            if (s_r.rxtk == 4'hf) begin
              s_nxt.rxpb = s_r.rxs2; // [RQ14]
              s_nxt.rxst = UFL_RX_STOP;
            end
          end
        end
        UFL_RX_STOP: begin
          if (tick) begin
            s_nxt.rxtk = 4'(s_r.rxtk + 4'h1);
            if (s_r.rxtk == 4'hf) begin
              s_nxt.rxst = UFL_RX_IDLE;
            end
          end
        end
        default: s_nxt.rxst = UFL_RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      s_r <= '0;
      s_r.bus1 <= 14'h3fff;
      s_r.bus2 <= 14'h3fff;
      s_r.line_format_control <= `UFL_LCR_RST;
      s_r.enhanced_feature_control <= `UFL_EFR_RST;
      s_r.div <= `UFL_DIV_RST;
      s_r.txst <= UFL_TX_IDLE;
      s_r.rxst <= UFL_RX_IDLE;
      s_r.txo <= 1'b1;
      s_r.rxs1 <= 1'b1;
      s_r.rxs2 <= 1'b1;
      s_r.rxs3 <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign data_out = s_r.dout;
  assign data_oe = s_r.oe;
  assign tx_line = s_r.txo;
  assign dma_mode = s_r.dma;
  assign rx_trigger_hit = s_r.rxhit;
  assign tx_trigger_hit = s_r.txhit;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n_s);
  sequence lsr_rd_s;
    rd_go && baddr == `UFL_A_LSR;
  endsequence
  sequence fcr_wr_s;
    wr_go && baddr == `UFL_A_FCR && s_r.line_format_control != `UFL_EFR_KEY;
  endsequence
  sequence tx_take_s;
    clk_en && tx_pop && !s_r.line_format_control[`UFL_LCR_BRK] && !s_nxt.line_format_control[`UFL_LCR_BRK];
  endsequence
  rx_present_a: assert property (lsr_rd_s |=> s_r.dout[0] == $past(rx_valid)) // [RQ18]
    else $error("status bit 0 disagrees with receive fill");
  ovr_set_a: assert property (clk_en && ovr_evt |=> s_r.ovr) // [RQ18]
    else $error("overrun not flagged");
  ovr_clear_a: assert property (lsr_rd_s ##0 !ovr_evt |=> !s_r.ovr) // [RQ23]
    else $error("overrun not cleared by status read");
  brk_hold_a: assert property (clk_en && s_nxt.line_format_control[`UFL_LCR_BRK] |=> !tx_line) // [RQ16]
    else $error("break does not hold TX low");
  rx_clear_a: assert property (fcr_wr_s ##0 bdata[`UFL_FCR_RXCLR] |=> rx_cnt == '0) // [RQ6]
    else $error("receive FIFO not emptied");
  tx_clear_a: assert property (fcr_wr_s ##0 bdata[`UFL_FCR_TXCLR] |=> tx_cnt == '0) // [RQ7]
    else $error("transmit FIFO not emptied");
  ptr_hold_a: assert property (lsr_rd_s ##0 !rx_push && !rx_clr |=> rx_cnt == $past(rx_cnt)) // [RQ22]
    else $error("status read moved the receive FIFO");
  err_flag_a: assert property (lsr_rd_s |=> s_r.dout[7] == ($past(s_r.errcnt) != '0)) // [RQ21]
    else $error("error-in-FIFO bit wrong");
  enh_lock_a: assert property (fcr_wr_s ##0 !s_r.enhanced_feature_control[`UFL_EFR_ENH] |=> $stable(s_r.txtrig)) // [RQ11]
    else $error("transmit trigger changed while locked");
  tx_start_a: assert property (tx_take_s |=> !tx_line ##1 (s_r.txst == UFL_TX_START)) // [RQ4]
    else $error("start bit not sent after FIFO take");
endmodule

// >>> ufl_peer.sv
// Remote serial device model: sends characters on rx_line, captures them from tx_line
`timescale 1ns/1ps
module ufl_peer #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk_sys,   // System clock
  input wire logic tx_line,   // Serial line from the block
  output logic rx_line        // Serial line into the block
);
  initial rx_line = 1'b1;
  // Start bit, eight data bits LSB first, one stop bit; stop_lvl 0 makes a framing fault
  task automatic send_char(input logic [7:0] d, input logic stop_lvl);
    logic [9:0] frame;
    frame = {stop_lvl, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_sys);
      #2 rx_line = frame[i];
      repeat (BIT_CLKS - 1) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    #2 rx_line = 1'b1;
    // Idle gap so a fault stop bit still sees a high before the next start
    repeat (3 * BIT_CLKS) @(posedge clk_sys);
  endtask
  // Waits a bounded time for a start bit, then samples each bit at its middle
  task automatic get_char(output logic [7:0] d, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    d = 8'h00;
    while (tx_line !== 1'b0 && n < 4000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n < 4000) begin
      ok = 1'b1;
      repeat (BIT_CLKS / 2) @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CLKS) @(posedge clk_sys);
        d[i] = tx_line;
      end
      repeat (BIT_CLKS) @(posedge clk_sys);
      if (tx_line !== 1'b1) ok = 1'b0;
    end
  endtask
endmodule

// >>> testbench.sv
// Self-checking testbench of the UART channel core
`timescale 1ns/1ps
`include "ufl_defs.svh"
module testbench;
  logic clk_sys, reset_n, cs_n, ior_n, iow_n, data_oe, rx_line, tx_line, dma_mode, rx_hit, tx_hit;
  logic [2:0] addr;
  logic [7:0] data_in, data_out, q;
  int n_mismatch = 0;
  int total_checks = 0;
  ufl_core #(.DEPTH(64)) uut (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(1'b1), .cs_n(cs_n),
    .ior_n(ior_n), .iow_n(iow_n), .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .rx_line(rx_line), .tx_line(tx_line), .dma_mode(dma_mode), .rx_trigger_hit(rx_hit),
    .tx_trigger_hit(tx_hit));
  ufl_peer #(.BIT_CLKS(16)) peer (.clk_sys(clk_sys), .tx_line(tx_line), .rx_line(rx_line));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  // Strobe held six clocks, then six clocks high before the next access
  task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #2 addr = a;
    data_in = d;
    cs_n = 1'b0;
    if (wr) iow_n = 1'b0;
    else ior_n = 1'b0;
    repeat (6) @(posedge clk_sys);
    q = data_out;
    chk({7'h00, !wr}, {7'h00, data_oe});
    #2 cs_n = 1'b1;
    ior_n = 1'b1;
    iow_n = 1'b1;
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(exp, q);
  endtask
  task automatic s_reset();
    rd_chk(`UFL_A_LSR, 8'h60);
    rd_chk(`UFL_A_LCR, `UFL_LCR_RST);
  endtask
  task automatic s_format();
    bus(1'b1, `UFL_A_LCR, 8'h1b);
    rd_chk(`UFL_A_LCR, 8'h1b);
    // Divisor low rewritten with its reset value, so the bit rate stays put
    bus(1'b1, `UFL_A_LCR, 8'h83);
    bus(1'b1, `UFL_A_DATA, 8'h01);
    rd_chk(`UFL_A_DATA, 8'h01);
    rd_chk(`UFL_A_DLH, 8'h00);
    bus(1'b1, `UFL_A_LCR, 8'h03);
  endtask
  task automatic s_tx();
    logic [7:0] d;
    logic ok;
    // Listener runs alongside the write so it sees the start bit's edge
    fork
      bus(1'b1, `UFL_A_DATA, 8'ha5);
      peer.get_char(d, ok);
    join
    if (ok !== 1'b1) begin
      n_mismatch++;
      wrap_up();
    end
    chk(8'ha5, d);
    // Stop bit still on the line when the listener returns
    repeat (16) @(posedge clk_sys);
    rd_chk(`UFL_A_LSR, 8'h60);
  endtask
  task automatic s_rx();
    bus(1'b1, `UFL_A_FCR, 8'h01);
    peer.send_char(8'h3c, 1'b1);
    peer.send_char(8'hc3, 1'b1);
    rd_chk(`UFL_A_LSR, 8'h61);
    rd_chk(`UFL_A_LSR, 8'h61);
    rd_chk(`UFL_A_DATA, 8'h3c);
    rd_chk(`UFL_A_DATA, 8'hc3);
    rd_chk(`UFL_A_LSR, 8'h60);
  endtask
  task automatic s_frame();
    peer.send_char(8'h55, 1'b0);
    peer.send_char(8'h0f, 1'b1);
    rd_chk(`UFL_A_LSR, 8'he9);
    rd_chk(`UFL_A_DATA, 8'h55);
    rd_chk(`UFL_A_LSR, 8'h61);
    rd_chk(`UFL_A_DATA, 8'h0f);
  endtask
  task automatic s_clear();
    peer.send_char(8'h11, 1'b1);
    bus(1'b1, `UFL_A_FCR, 8'h03);
    rd_chk(`UFL_A_LSR, 8'h60);
  endtask
  task automatic s_over();
    bus(1'b1, `UFL_A_FCR, 8'h00);
    peer.send_char(8'h21, 1'b1);
    peer.send_char(8'h42, 1'b1);
    rd_chk(`UFL_A_LSR, 8'h63);
    rd_chk(`UFL_A_LSR, 8'h61);
    rd_chk(`UFL_A_DATA, 8'h42);
  endtask
  task automatic s_dma();
    bus(1'b1, `UFL_A_FCR, 8'h09);
    chk(8'h01, {7'h00, dma_mode});
    chk(8'h01, {7'h00, tx_hit});
    bus(1'b1, `UFL_A_FCR, 8'h01);
    chk(8'h00, {7'h00, dma_mode});
  endtask
  task automatic s_trig();
    for (int i = 0; i < 7; i++) begin
      peer.send_char(8'h30, 1'b1);
    end
    chk(8'h00, {7'h00, rx_hit});
    peer.send_char(8'h31, 1'b1);
    chk(8'h01, {7'h00, rx_hit});
    bus(1'b1, `UFL_A_FCR, 8'h03);
    chk(8'h00, {7'h00, rx_hit});
    rd_chk(`UFL_A_LSR, 8'h60);
  endtask
  task automatic s_break();
    bus(1'b1, `UFL_A_LCR, 8'h43);
    repeat (20) @(posedge clk_sys);
    chk(8'h00, {7'h00, tx_line});
    bus(1'b1, `UFL_A_LCR, 8'h03);
    chk(8'h01, {7'h00, tx_line});
  endtask
  initial begin
    reset_n = 1'b0;
    cs_n = 1'b1;
    ior_n = 1'b1;
    iow_n = 1'b1;
    addr = 3'h0;
    data_in = 8'h00;
    repeat (4) @(posedge clk_sys);
    #2 reset_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    s_reset();
    s_format();
    s_tx();
    s_rx();
    s_frame();
    s_clear();
    s_over();
    s_dma();
    s_trig();
    s_break();
    wrap_up();
  end
endmodule
